// ### design/rids_pkg.sv
// rids_pkg: shared constants of the receiver id display sequencer
// assumes an apb slave with 32-bit data and a 25 MHz system clock
package rids_pkg;

   // apb byte offsets, one aligned word each
   localparam logic [11:0] OFF_CTRL    = 12'h000;
   localparam logic [11:0] OFF_STATUS  = 12'h004;
   localparam logic [11:0] OFF_RX_BASE = 12'h008;

   // ctrl fields and reset value
   localparam int          CTRL_ENABLE_BIT = 0;
   localparam logic        CTRL_ENABLE_RST = 1'b1;

   // status fields
   localparam int          STAT_SEQ_LSB    = 0;
   localparam int          STAT_IDLE_BIT   = 4;
   localparam int          STAT_BAD_LSB    = 5;
   localparam int          STAT_LOST_BIT   = 8;

   // rx code register fields
   localparam int          RXC_SER_LSB     = 0;
   localparam int          RXC_BAND_LSB    = 8;

   // character construction
   localparam logic [1:0]  CHAR_BITS_5_4   = 2'h3;
   localparam logic [6:0]  CH_SPACE        = 7'h20;
   localparam logic [6:0]  CH_DOT          = 7'h2E;
   localparam logic [6:0]  CH_ZERO         = 7'h30;
   localparam logic [6:0]  CH_A            = 7'h41;
   localparam logic [6:0]  CH_B            = 7'h42;
   localparam logic [6:0]  CH_D            = 7'h44;

   // band codes above this, or with the parity bit set, read as bad
   localparam logic [3:0]  BAND_LAST_VALID = 4'hA;

   // phase that selects no receiver
   localparam logic [1:0]  PHASE_IDLE      = 2'h3;

   // timing: clock rate and calibration loss timeout
   localparam int          CLK_KHZ         = 25000;
   localparam int          CAL_LOSS_MS     = 250;
   localparam int          CAL_LOSS_CYC    = CAL_LOSS_MS * CLK_KHZ;

endpackage

// ### design/rids_band_rom.sv
// rids_band_rom: band code plus parity to four display characters
// assumes pos_i counts 0..3 from the rightmost character position
`timescale 1ns/10ps
`default_nettype none
module rids_band_rom #(
   parameter int BAND_W = 5
) (
   input  wire logic [BAND_W-1:0] band_i,
   input  wire logic [1:0]        pos_i,
   output logic      [6:0]        char_o
);

   logic [27:0] disp;

   generate
      if (BAND_W != 5) begin : g_chk
         $error("rids_band_rom: BAND_W must be 5");
      end
   endgenerate

   // four characters, leftmost in the top seven bits; a table beats arithmetic here
   always_comb begin
      disp = {rids_pkg::CH_SPACE, rids_pkg::CH_B, rids_pkg::CH_A, rids_pkg::CH_D};
      if (!band_i[4] && band_i[3:0] <= rids_pkg::BAND_LAST_VALID) begin
         case (band_i[3:0])
            4'h0:    disp = {7'h34, 7'h30, 7'h30, rids_pkg::CH_DOT};
            4'h1:    disp = {7'h35, 7'h30, rids_pkg::CH_DOT, 7'h30};
            4'h2:    disp = {7'h32, 7'h30, rids_pkg::CH_DOT, 7'h30};
            4'h3:    disp = {7'h31, 7'h33, rids_pkg::CH_DOT, 7'h30};
            4'h4:    disp = {rids_pkg::CH_SPACE, 7'h36, rids_pkg::CH_DOT, 7'h30};
            4'h5:    disp = {rids_pkg::CH_SPACE, 7'h33, rids_pkg::CH_DOT, 7'h36};
            4'h6:    disp = {rids_pkg::CH_SPACE, 7'h32, rids_pkg::CH_DOT, 7'h38};
            4'h7:    disp = {rids_pkg::CH_SPACE, 7'h32, rids_pkg::CH_DOT, 7'h30};
            4'h8:    disp = {rids_pkg::CH_SPACE, 7'h31, rids_pkg::CH_DOT, 7'h33};
            4'h9:    disp = {rids_pkg::CH_SPACE, 7'h30, rids_pkg::CH_DOT, 7'h37};
            4'hA:    disp = {7'h30, rids_pkg::CH_DOT, 7'h33, 7'h35};
            default: disp = {rids_pkg::CH_SPACE, rids_pkg::CH_B, rids_pkg::CH_A, rids_pkg::CH_D};
         endcase
      end
   end

   // position 0 is the rightmost character
   always_comb begin
      char_o = disp[pos_i*7 +: 7];
   end

endmodule
`default_nettype wire

// ### design/rids_sequencer.sv
// rids_sequencer: refreshes three serial-number and band displays from receiver codes
// assumes the calibration switching signal and all receiver codes are asynchronous pins,
// and an apb master that holds each request until pready
`timescale 1ns/10ps
`default_nettype none
module rids_sequencer #(
   parameter int SER_W         = 6,
   parameter int BAND_W        = 5,
   parameter int CAL_LOSS_CYC  = rids_pkg::CAL_LOSS_CYC
) (
   input  wire logic                clk_i,
   input  wire logic                reset_i,
   // apb slave
   input  wire logic                psel_i,
   input  wire logic                penable_i,
   input  wire logic                pwrite_i,
   input  wire logic [11:0]         paddr_i,
   input  wire logic [31:0]         pwdata_i,
   output logic      [31:0]         prdata_o,
   output logic                     pready_o,
   output logic                     pslverr_o,
   // calibration switching pin
   input  wire logic                cal_clk_i,
   // receiver code pins, receiver a in the low slice
   input  wire logic [3*SER_W-1:0]  ser_code_i,
   input  wire logic [3*BAND_W-1:0] band_code_i,
   // display side
   output logic      [6:0]          ser_char_o,
   output logic      [6:0]          band_char_o,
   output logic                     char_pos_lsb_o,
   output logic                     char_pos_msb_o,
   output logic                     rx_a_char_strobe_n_o,
   output logic                     rx_b_char_strobe_n_o,
   output logic                     rx_c_char_strobe_n_o,
   output logic      [3:0]          seq_o
);

   localparam int LOSS_W = $clog2(CAL_LOSS_CYC + 1);

   generate
      if (SER_W != 6) begin : g_chk_ser
         $error("rids_sequencer: SER_W must be 6");
      end
      if (BAND_W != 5) begin : g_chk_band
         $error("rids_sequencer: BAND_W must be 5");
      end
      if (CAL_LOSS_CYC < 2) begin : g_chk_loss
         $error("rids_sequencer: CAL_LOSS_CYC must be at least 2");
      end
   endgenerate

   typedef struct packed {
      logic                cal_s1;
      logic                cal_s2;
      logic                cal_lvl;
      logic                cal_late;
      logic [3*SER_W-1:0]  ser_s1;
      logic [3*SER_W-1:0]  ser_s2;
      logic [3*BAND_W-1:0] band_s1;
      logic [3*BAND_W-1:0] band_s2;
      logic [3:0]          seq;
      logic [6:0]          ser_char;
      logic [6:0]          band_char;
      logic [1:0]          pos;
      logic [2:0]          strobe_n;
      logic                enable;
      logic [2:0]          band_bad;
      logic [LOSS_W-1:0]   loss_cnt;
      logic                cal_lost;
      logic                pready;
      logic                pslverr;
      logic [31:0]         prdata;
   } rids_state_t;

   rids_state_t q;
   rids_state_t d;

   logic [1:0]        phase;
   logic [SER_W-1:0]  ser_sel;
   logic [BAND_W-1:0] band_sel;
   logic [3:0]        low_decimal_digit;
   logic [3:0]        high_decimal_digit;
   logic [3:0]        digit;
   logic [2:0]        half_quot;
   logic [2:0]        half_rem;
   logic [6:0]        rom_char;
   logic              cal_rise;
   logic              sel_bad;
   logic              access;
   logic [11:0]       rx_off;
   logic [1:0]        rx_idx;
   logic              phase_live;
   logic              cal_step;
   logic              loss_hit;
   logic [3:0]        seq_next;
   logic [6:0]        ser_char_next;
   logic              decoder_gate;
   logic [2:0]        strobe_dec_n;
   logic              hit_ctrl;
   logic              hit_status;
   logic              hit_rx;
   logic              rd_err;
   logic [31:0]       ctrl_word;
   logic [31:0]       status_word;
   logic [31:0]       rx_word;
   logic [31:0]       rd_word;

   assign phase = q.seq[3:2];

   // both converters see the whole code of one receiver at once
   always_comb begin
      ser_sel  = '0;
      band_sel = '0;
      case (phase)
         2'h0: begin
            ser_sel  = q.ser_s2[0*SER_W +: SER_W];
            band_sel = q.band_s2[0*BAND_W +: BAND_W];
         end
         2'h1: begin
            ser_sel  = q.ser_s2[1*SER_W +: SER_W];
            band_sel = q.band_s2[1*BAND_W +: BAND_W];
         end
         2'h2: begin
            ser_sel  = q.ser_s2[2*SER_W +: SER_W];
            band_sel = q.band_s2[2*BAND_W +: BAND_W];
         end
         default: begin
            ser_sel  = '0;
            band_sel = '0;
         end
      endcase
   end

   // value = 2*h + b0, so tens = h/5 and ones = 2*(h%5) + b0
   always_comb begin
      half_quot          = 3'(ser_sel[5:1] / 5'h05);
      half_rem           = 3'(ser_sel[5:1] % 5'h05);
      low_decimal_digit  = {half_rem, ser_sel[0]};
      high_decimal_digit = {1'b0, half_quot};
      case (q.seq[1:0])
         2'h0:    digit = low_decimal_digit;
         2'h1:    digit = high_decimal_digit;
         default: digit = 4'h0;
      endcase
   end

   rids_band_rom #(
      .BAND_W (BAND_W)
   ) u_band_rom (
      .band_i (band_sel),
      .pos_i  (q.seq[1:0]),
      .char_o (rom_char)
   );

   assign sel_bad    = band_sel[4] | (band_sel[3:0] > rids_pkg::BAND_LAST_VALID);
   assign phase_live = (phase != rids_pkg::PHASE_IDLE);
   assign cal_step   = q.cal_s2 & ~q.cal_lvl;
   assign cal_rise   = q.cal_lvl & ~q.cal_late;
   assign loss_hit   = (q.loss_cnt == LOSS_W'(CAL_LOSS_CYC));
   assign access     = psel_i & penable_i;
   assign rx_off     = paddr_i - rids_pkg::OFF_RX_BASE;
   assign rx_idx     = rx_off[3:2];

   // reset loads zero; from any state the next calibration step moves the counter on by one
   always_comb begin
      seq_next = q.seq;
      if (cal_step) begin
         seq_next = q.seq + 4'h1;
      end
   end

   // upper bits 011 make digits; 111 in the two left positions leaves them dark
   always_comb begin
      ser_char_next = {q.seq[1], rids_pkg::CHAR_BITS_5_4, digit};
   end

   // timing in system clocks after a calibration edge reaches the pin:
   // +3 the counter steps, +4 address and characters move, +5 the strobe falls;
   // the strobe rises five clocks after the pin falls, so the characters have stood
   // for about half a calibration period when the display latches them
   always_comb begin
      decoder_gate = q.cal_late & q.enable;
      strobe_dec_n = 3'h7;
      if (decoder_gate) begin
         case (phase)
            2'h0:    strobe_dec_n = 3'h6;
            2'h1:    strobe_dec_n = 3'h5;
            2'h2:    strobe_dec_n = 3'h3;
            default: strobe_dec_n = 3'h7;
         endcase
      end
   end

   // address decode; the three rx words sit on aligned offsets after the base
   always_comb begin
      hit_ctrl   = (paddr_i == rids_pkg::OFF_CTRL);
      hit_status = (paddr_i == rids_pkg::OFF_STATUS);
      hit_rx     = (paddr_i >= rids_pkg::OFF_RX_BASE) && (rx_off < 12'h00C) && (paddr_i[1:0] == 2'h0);
   end

   // read words are built every cycle; only the first access cycle captures one
   always_comb begin
      ctrl_word                                = '0;
      ctrl_word[rids_pkg::CTRL_ENABLE_BIT]     = q.enable;
      status_word                              = '0;
      status_word[rids_pkg::STAT_SEQ_LSB +: 4] = q.seq;
      status_word[rids_pkg::STAT_IDLE_BIT]     = !phase_live;
      status_word[rids_pkg::STAT_BAD_LSB +: 3] = q.band_bad;
      status_word[rids_pkg::STAT_LOST_BIT]     = q.cal_lost;
      rx_word                                  = '0;
      case (rx_idx)
         2'h0: begin
            rx_word[rids_pkg::RXC_SER_LSB +: SER_W]   = q.ser_s2[0*SER_W +: SER_W];
            rx_word[rids_pkg::RXC_BAND_LSB +: BAND_W] = q.band_s2[0*BAND_W +: BAND_W];
         end
         2'h1: begin
            rx_word[rids_pkg::RXC_SER_LSB +: SER_W]   = q.ser_s2[1*SER_W +: SER_W];
            rx_word[rids_pkg::RXC_BAND_LSB +: BAND_W] = q.band_s2[1*BAND_W +: BAND_W];
         end
         2'h2: begin
            rx_word[rids_pkg::RXC_SER_LSB +: SER_W]   = q.ser_s2[2*SER_W +: SER_W];
            rx_word[rids_pkg::RXC_BAND_LSB +: BAND_W] = q.band_s2[2*BAND_W +: BAND_W];
         end
         default: begin
            rx_word = '0;
         end
      endcase
   end

   // only ctrl takes writes; status and rx words are read only,
   // and anything unmapped or misaligned answers with an error
   always_comb begin
      rd_word = '0;
      rd_err  = 1'b0;
      if (hit_ctrl) begin
         rd_word = ctrl_word;
      end else if (hit_status && !pwrite_i) begin
         rd_word = status_word;
      end else if (hit_rx && !pwrite_i) begin
         rd_word = rx_word;
      end else begin
         rd_err = 1'b1;
      end
   end

   always_comb begin
      d = q;

      // pins pass two flops before use
      d.cal_s1  = cal_clk_i;
      d.cal_s2  = q.cal_s1;
      d.cal_lvl = q.cal_s2;
      d.cal_late = q.cal_lvl;
      d.ser_s1  = ser_code_i;
      d.ser_s2  = q.ser_s1;
      d.band_s1 = band_code_i;
      d.band_s2 = q.band_s1;

      // counter wraps freely; a bad start state is overwritten within one lap
      d.seq = seq_next;

      // data follow the counter one cycle later, before the strobe falls
      d.pos       = q.seq[1:0];
      d.ser_char  = ser_char_next;
      d.band_char = rom_char;

      // strobe lags the data by a cycle so setup holds; release edge latches the display
      d.strobe_n = strobe_dec_n;

      // band error seen during each receiver's phase
      if (phase_live) begin
         d.band_bad[phase] = sel_bad;
      end

      // calibration loss watchdog; a stopped clock freezes the displays
      if (cal_rise) begin
         d.loss_cnt = '0;
         d.cal_lost = 1'b0;
      end else if (loss_hit) begin
         d.cal_lost = 1'b1;
      end else begin
         d.loss_cnt = q.loss_cnt + LOSS_W'(1);
      end

      // apb: one wait state, then the transfer completes with pready high
      d.pready  = 1'b0;
      d.pslverr = 1'b0;
      if (access && !q.pready) begin
         d.pready  = 1'b1;
         d.prdata  = rd_word;
         d.pslverr = rd_err;
      end else if (access && q.pready) begin
         d.prdata = q.prdata;
         if (pwrite_i && hit_ctrl) begin
            d.enable = pwdata_i[rids_pkg::CTRL_ENABLE_BIT];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         q          <= '0;
         q.strobe_n <= 3'h7;
         q.enable   <= rids_pkg::CTRL_ENABLE_RST;
      end else begin
         q <= d;
      end
   end

   assign prdata_o             = q.prdata;
   assign pready_o             = q.pready;
   assign pslverr_o            = q.pslverr;
   assign ser_char_o           = q.ser_char;
   assign band_char_o          = q.band_char;
   assign char_pos_lsb_o       = q.pos[0];
   assign char_pos_msb_o       = q.pos[1];
   assign rx_a_char_strobe_n_o = q.strobe_n[0];
   assign rx_b_char_strobe_n_o = q.strobe_n[1];
   assign rx_c_char_strobe_n_o = q.strobe_n[2];
   assign seq_o                = q.seq;

endmodule
`default_nettype wire

// ### dv/rids_chk.sv
// rids_chk: port assertions for the display sequencer
// assumes it is bound to rids_sequencer and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module rids_chk (
   input wire logic       clk_i,
   input wire logic       reset_i,
   input wire logic [6:0] ser_char_o,
   input wire logic       char_pos_lsb_o,
   input wire logic       char_pos_msb_o,
   input wire logic       rx_a_char_strobe_n_o,
   input wire logic       rx_b_char_strobe_n_o,
   input wire logic       rx_c_char_strobe_n_o,
   input wire logic [3:0] seq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   wire logic [1:0] pos = {char_pos_msb_o, char_pos_lsb_o};
   wire logic [2:0] stb_n = {rx_c_char_strobe_n_o, rx_b_char_strobe_n_o, rx_a_char_strobe_n_o};
   wire logic       all_off = &stb_n;
   // a reset edge also moves the counter, so it is kept out of the antecedent
   sequence s_new_state;
      !$past(reset_i) && !$stable(seq_o);
   endsequence
   seq_step_a: assert property (s_new_state |-> seq_o == $past(seq_o) + 4'h1)
      else $error("counter did not step by one");
   pos_map_a: assert property (s_new_state |=> pos == $past(seq_o[1:0]))
      else $error("address does not follow counter");
   ser_upper_a: assert property (s_new_state |=> ser_char_o[6:4] == {$past(seq_o[1]), 2'h3})
      else $error("serial upper bits wrong");
   ser_blank_a: assert property (s_new_state ##0 seq_o[1] |=> ser_char_o[3:0] == 4'h0)
      else $error("upper serial digits not zero");
   msd_top_a: assert property (s_new_state ##0 (seq_o[1:0] == 2'h1) |=> !ser_char_o[3])
      else $error("tens digit top bit set");
   idle_quiet_a: assert property (seq_o[3:2] == 2'h3 |-> all_off)
      else $error("strobe in idle phase");
   strobe_phase_a: assert property (all_off || stb_n == ~(3'h1 << seq_o[3:2]))
      else $error("wrong receiver strobed");
   data_hold_a: assert property ($rose(all_off) |-> $stable(pos) && $stable(ser_char_o[6:4]))
      else $error("address moved at latch edge");
endmodule
bind rids_sequencer rids_chk u_chk (
   .clk_i(clk_i), .reset_i(reset_i), .ser_char_o(ser_char_o),
   .char_pos_lsb_o(char_pos_lsb_o), .char_pos_msb_o(char_pos_msb_o),
   .rx_a_char_strobe_n_o(rx_a_char_strobe_n_o), .rx_b_char_strobe_n_o(rx_b_char_strobe_n_o),
   .rx_c_char_strobe_n_o(rx_c_char_strobe_n_o), .seq_o(seq_o));
`default_nettype wire

// ### dv/rids_disp_model.sv
// rids_disp_model: three serial and band displays with character ram
// assumes a character is stored on the rising edge of its active-low strobe
`timescale 1ns/10ps
`default_nettype none
module rids_disp_model (
   input wire logic       stb_a_n_i,
   input wire logic       stb_b_n_i,
   input wire logic       stb_c_n_i,
   input wire logic [1:0] pos_i,
   input wire logic [6:0] ser_char_i,
   input wire logic [6:0] band_char_i
);
   logic [6:0] ser_mem [3][4];
   logic [6:0] band_mem [3][4];
   task automatic store(input int rx);
      ser_mem[rx][pos_i] = ser_char_i;
      band_mem[rx][pos_i] = band_char_i;
   endtask
   always @(posedge stb_a_n_i) store(0);
   always @(posedge stb_b_n_i) store(1);
   always @(posedge stb_c_n_i) store(2);
   // dark positions read back as a space
   function automatic logic [6:0] shown(input logic [6:0] c);
      return (c[6] == c[5]) ? 7'h20 : c;
   endfunction
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// tb_top: self-checking bench for rids_sequencer and one model of its three displays
// assumes a fast stand-in calibration clock of CAL_P system clocks
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam int CAL_P = 40;
   logic        clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cal_clk = 1'b0, cal_run = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, err, pos_l, pos_m, wa, wb, wc;
   logic [17:0] ser = 18'h0;
   logic [14:0] band = 15'h0;
   logic [6:0]  ser_ch, band_ch;
   int          fail_count = 0, checks = 0, cal_cnt = 0, n_low [3];
   always #20 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cal_cnt <= (cal_cnt == CAL_P - 1) ? 0 : cal_cnt + 1;
      cal_clk <= cal_run && cal_cnt < CAL_P / 2;
   end
   always @(negedge wa) n_low[0]++;
   always @(negedge wb) n_low[1]++;
   always @(negedge wc) n_low[2]++;
   rids_sequencer #(.CAL_LOSS_CYC(200)) u_dut (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .cal_clk_i(cal_clk), .ser_code_i(ser), .band_code_i(band),
      .ser_char_o(ser_ch), .band_char_o(band_ch), .char_pos_lsb_o(pos_l), .char_pos_msb_o(pos_m),
      .rx_a_char_strobe_n_o(wa), .rx_b_char_strobe_n_o(wb), .rx_c_char_strobe_n_o(wc), .seq_o());
   rids_disp_model u_disp (.stb_a_n_i(wa), .stb_b_n_i(wb), .stb_c_n_i(wc), .pos_i({pos_m, pos_l}),
      .ser_char_i(ser_ch), .band_char_i(band_ch));
   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready !== 1'b1 && n < 10);
      if (n >= 10) begin
         chk("pready", 32'h0, 32'h1);
         summarize();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [6:0] ser_exp(input logic [5:0] v, input int p);
      if (p == 0) return 7'h30 + 7'(v % 10);
      if (p == 1) return 7'h30 + 7'(v / 10);
      return 7'h20;
   endfunction
   function automatic logic [6:0] band_exp(input logic [4:0] b, input int p);
      string s;
      string t [11] = '{"400.", "50.0", "20.0", "13.0", " 6.0", " 3.6", " 2.8", " 2.0", " 1.3", " 0.7", "0.35"};
      s = (b <= 5'h0A) ? t[b] : " BAD";
      return 7'(s[3 - p]);
   endfunction
   function automatic logic is_bad(input logic [4:0] b);
      return b[4] || (b[3:0] > 4'hA);
   endfunction
   // strobes are counted over exactly one 16-state cycle, sampled off the launching edge
   task automatic run_cycle(input int exp_pulses);
      repeat (2 * CAL_P) @(posedge clk_i);
      @(negedge clk_i);
      n_low = '{0, 0, 0};
      repeat (16 * CAL_P) @(negedge clk_i);
      for (int r = 0; r < 3; r++) chk("strobes per cycle", n_low[r], exp_pulses);
   endtask
   initial begin
      void'($urandom(40765));
      repeat (5) @(posedge clk_i);
      reset_i <= 1'b0;
      apb(1'b0, 12'h000, 32'h0);
      chk("ctrl reset", rd, 32'h1);
      apb(1'b1, 12'h004, 32'h0);
      chk("status write refused", {31'h0, err}, 32'h1);
      apb(1'b0, 12'h0FC, 32'h0);
      chk("unmapped refused", {31'h0, err}, 32'h1);
      apb(1'b1, 12'h000, 32'h0);
      run_cycle(0);
      apb(1'b1, 12'h000, 32'h1);
      $display("test registers done");
      for (int i = 0; i < 7; i++) begin
         @(posedge clk_i);
         if (i == 0) begin
            ser <= {6'd63, 6'd10, 6'd1};
            band <= {5'h1F, 5'h0A, 5'h00};
         end else if (i == 1) begin
            ser <= {6'd9, 6'd20, 6'd59};
            band <= {5'h10, 5'h0B, 5'h06};
         end else
            for (int r = 0; r < 3; r++) begin
               ser[6*r +: 6] <= 6'($urandom_range(63, 1));
               band[5*r +: 5] <= 5'($urandom_range(31, 0));
            end
         run_cycle(4);
         for (int r = 0; r < 3; r++)
            for (int p = 0; p < 4; p++) begin
               chk("serial char", u_disp.shown(u_disp.ser_mem[r][p]), ser_exp(ser[6*r +: 6], p));
               chk("band char", u_disp.shown(u_disp.band_mem[r][p]), band_exp(band[5*r +: 5], p));
            end
         for (int r = 0; r < 3; r++) begin
            apb(1'b0, 12'h008 + 12'(4 * r), 32'h0);
            chk("rx code", rd, {19'h0, band[5*r +: 5], 2'h0, ser[6*r +: 6]});
         end
         apb(1'b0, 12'h004, 32'h0);
         chk("band flags", rd[8:5], {1'b0, is_bad(band[14:10]), is_bad(band[9:5]), is_bad(band[4:0])});
         $display("test codes %0d done", i);
      end
      cal_run <= 1'b0;
      repeat (300) @(posedge clk_i);
      apb(1'b0, 12'h004, 32'h0);
      chk("calibration lost", {31'h0, rd[8]}, 32'h1);
      $display("test calibration loss done");
      summarize();
   end
endmodule
`default_nettype wire
